/* core/sro_pkg.sv */
package sro_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SRO_FLAG_REG_ADDR = 8'h86;
  localparam int SRO_CAUSE_UP_BIT = 7;
  localparam int SRO_CAUSE_LO_BIT = 6;
  localparam int SRO_LV_HIGH_BIT = 5;
  localparam int SRO_LV_MID_BIT = 4;
  localparam int SRO_ALU_MSB = 2;
  localparam logic [2:0] SRO_ALU_RST = 3'h0;
  localparam logic [7:0] SRO_RD_IDLE = 8'h00;

  // Reset cause codes held in the two status bits
  localparam logic [1:0] SRO_CAUSE_WDT = 2'h0;
  localparam logic [1:0] SRO_CAUSE_POR = 2'h2;
  localparam logic [1:0] SRO_CAUSE_EXT = 2'h3;

  // ----------------------------------------------------------------
  // Factory option encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SRO_HCLK_PLL = 2'h0;
  localparam logic [1:0] SRO_HCLK_RC = 2'h1;
  localparam logic [1:0] SRO_HCLK_X12 = 2'h2;
  localparam logic [1:0] SRO_HCLK_X4 = 2'h3;
  localparam logic SRO_LCLK_XTAL = 1'b0;
  localparam logic SRO_LCLK_RC = 1'b1;
  localparam logic [1:0] SRO_WDT_OFF = 2'h0;
  localparam logic [1:0] SRO_WDT_EN = 2'h1;
  localparam logic [1:0] SRO_WDT_ON = 2'h2;
  localparam logic [1:0] SRO_LVD_L = 2'h0;
  localparam logic [1:0] SRO_LVD_M = 2'h1;
  localparam logic [1:0] SRO_LVD_H = 2'h2;
  localparam logic [1:0] SRO_LVD_MAX = 2'h3;
  localparam logic SRO_PIN_RESET = 1'b0;
  localparam logic SRO_PIN_INPUT = 1'b1;
  // Normal-mode divider select: 0../1 .. 4../16
  localparam logic [2:0] SRO_FCPU_MAX_SEL = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SRO_CLK_MHZ = 25;
  localparam int SRO_POWER_WAIT_US = 100;
  localparam int SRO_POWER_WAIT_CYC = SRO_POWER_WAIT_US * SRO_CLK_MHZ;
  localparam int SRO_RC_WARM_US = 2;
  localparam int SRO_RC_WARM_CYC = SRO_RC_WARM_US * SRO_CLK_MHZ;
  localparam int SRO_XTAL_WARM_US = 2000;
  // Fast clock cycles per slow oscillator period, about 32 kHz
  localparam int SRO_SLOW_DIV_CYC = 763;
  localparam logic [3:0] SRO_SLOW_FCPU_DIV = 4'h4;
  localparam int SRO_CNT_W = 17;

  typedef enum logic [2:0] {
    SRO_ST_POWER,
    SRO_ST_PIN,
    SRO_ST_INIT,
    SRO_ST_WARM,
    SRO_ST_RUN
  } sro_state_type;

endpackage : sro_pkg

/* core/sro_cpu_div.sv */
`timescale 1ns/100ps
`default_nettype none
module sro_cpu_div
  import sro_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic slow_mode,
  input wire logic [2:0] fcpu_sel,
  input wire logic slow_tick,
  output logic cyc_tick
);

  logic [3:0] cnt_r;
  logic [3:0] limit;
  logic mode_q_r;

  // Out-of-range selects fall back to the slowest rate
  always_comb begin
    if (fcpu_sel > SRO_FCPU_MAX_SEL) begin
      limit = 4'hF;
    end else begin
      limit = 4'((5'h01 << fcpu_sel) - 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // Instruction-cycle enable
  // ----------------------------------------------------------------
  // Mode change restarts the count so no short cycle leaks across
  always_ff @(posedge ref_clk) begin
    mode_q_r <= srst ? 1'b0 : slow_mode;
    if (srst || mode_q_r != slow_mode) begin
      cnt_r <= 4'h0;
      cyc_tick <= 1'b0;
    end else if (slow_mode) begin
      cyc_tick <= slow_tick && (cnt_r == SRO_SLOW_FCPU_DIV - 4'h1);
      if (slow_tick) begin
        cnt_r <= (cnt_r == SRO_SLOW_FCPU_DIV - 4'h1) ? 4'h0 : cnt_r + 4'h1;
      end
    end else begin
      cyc_tick <= (cnt_r >= limit);
      cnt_r <= (cnt_r >= limit) ? 4'h0 : cnt_r + 4'h1;
    end
  end

endmodule : sro_cpu_div
`default_nettype wire

/* core/sro_reset_ctrl.sv */
// What this block does
// - Reset on power-on, watchdog overflow, brown-out, or enabled external pin.
// - Reset restores registers, halts execution, clears PC; fetch restarts at zero.
// - Cause bits 7:6 read 00 watchdog, 10 power/low-voltage, 11 external pin.
// - Power-on waits for a stable supply before the next step.
// - With pin reset enabled, hold reset while the pin is low.
// - After source step: initialise, oscillator warm-up, then execute.
// - Watchdog overflow resets, then initialise, warm-up and execute again.
// - Warm-up is short for RC oscillator, longer for crystal.
// - In reset-pin mode a falling pin edge resets the system.
// - Input-only pin option disables external reset; pin is plain input.
// - Slow mode runs instruction cycle at slow clock over four.
// - Instruction-rate option applies only to normal fast-clock mode.
// - Slow RC option drives slow clock on the slow output pin.
// - Fast RC option drives instruction clock on the fast output pin.
// - Internal PLL option turns fast output pin into bidirectional GPIO.
// - Security option blocks program memory readout.
// - PLL, slow crystal and watchdog on: no sleep, green mode still allowed.
// - Normal instruction cycle is fast clock over 1, 2, 4, 8 or 16.
// - Any low-voltage reset clears both low-voltage flags.
// - Always-on watchdog runs in power-down and green; enabled one stops.
`timescale 1ns/100ps
`default_nettype none
module sro_reset_ctrl
  import sro_pkg::*;
#(
  parameter int XTAL_WARM_CYC = SRO_XTAL_WARM_US * SRO_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic power_good,
  input wire logic wdt_overflow,
  input wire logic lvd_reset,
  input wire logic lvd_mid_in,
  input wire logic lvd_high_in,
  input wire logic rst_pin_in,
  input wire logic [1:0] opt_high_clk,
  input wire logic opt_low_clk,
  input wire logic [2:0] opt_fcpu,
  input wire logic [1:0] opt_wdt,
  input wire logic opt_reset_pin,
  input wire logic opt_security,
  input wire logic [1:0] opt_lvd,
  input wire logic slow_mode,
  input wire logic power_down_mode,
  input wire logic green_mode,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic fast_osc_out_pin_i,
  input wire logic rom_dump_req,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic core_rst,
  output logic regs_init,
  output logic fetch_go,
  output logic fcpu_tick,
  output logic wdt_run,
  output logic sleep_allowed,
  output logic green_allowed,
  output logic rom_dump_grant,
  output logic fast_osc_out_pin_o,
  output logic fast_osc_out_pin_oe,
  output logic slow_osc_out_pin_o,
  output logic slow_osc_out_pin_oe,
  output logic gpio_in,
  output logic gpi_pin_in
);

  sro_state_type st_r;
  sro_state_type st_nxt;
  logic [SRO_CNT_W-1:0] cnt_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic pin_fall;
  logic pin_rst_en;
  logic wdt_hit;
  logic [1:0] cause_r;
  logic lv_mid_r;
  logic lv_high_r;
  logic [2:0] alu_r;
  logic [9:0] slow_cnt_r;
  logic slow_tick_r;
  logic cyc_tick;
  logic flag_reg_sel;
  logic [SRO_CNT_W-1:0] warm_cyc;

  // ----------------------------------------------------------------
  // Reset pin input
  // ----------------------------------------------------------------
  // Two-flop synchroniser, edge seen only between stages two and three
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
    end else begin
      pin_s1_r <= rst_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_rst_en = (opt_reset_pin == SRO_PIN_RESET);
  assign pin_fall = pin_rst_en && pin_s3_r && !pin_s2_r;
  assign wdt_hit = wdt_overflow && (opt_wdt != SRO_WDT_OFF) && (st_r == SRO_ST_RUN);

  always_ff @(posedge ref_clk) begin
    gpi_pin_in <= srst ? 1'b1 : (!pin_rst_en && pin_s2_r);
  end

  // ----------------------------------------------------------------
  // Reset sequence
  // ----------------------------------------------------------------
  assign warm_cyc = (opt_high_clk == SRO_HCLK_RC) ? SRO_CNT_W'(SRO_RC_WARM_CYC)
                                                  : SRO_CNT_W'(XTAL_WARM_CYC);

  // Brown-out outranks watchdog, watchdog outranks pin edge
  always_comb begin
    st_nxt = st_r;
    if (lvd_reset) begin
      st_nxt = SRO_ST_POWER;
    end else if (wdt_hit) begin
      st_nxt = SRO_ST_INIT;
    end else if (pin_fall && st_r != SRO_ST_POWER) begin
      st_nxt = SRO_ST_PIN;
    end else begin
      unique case (st_r)
        SRO_ST_POWER: begin
          if (power_good && cnt_r == '0) begin
            st_nxt = SRO_ST_PIN;
          end
        end
        SRO_ST_PIN: begin
          if (!pin_rst_en || pin_s2_r) begin
            st_nxt = SRO_ST_INIT;
          end
        end
        SRO_ST_INIT: begin
          st_nxt = SRO_ST_WARM;
        end
        SRO_ST_WARM: begin
          if (cnt_r == '0) begin
            st_nxt = SRO_ST_RUN;
          end
        end
        SRO_ST_RUN: begin
          st_nxt = SRO_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= SRO_ST_POWER;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Supply must stay good for the whole wait; a dip restarts it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_r <= SRO_CNT_W'(SRO_POWER_WAIT_CYC - 1);
    end else if (st_nxt == SRO_ST_POWER && (st_r != SRO_ST_POWER || !power_good)) begin
      cnt_r <= SRO_CNT_W'(SRO_POWER_WAIT_CYC - 1);
    end else if (st_nxt == SRO_ST_WARM && st_r != SRO_ST_WARM) begin
      cnt_r <= warm_cyc - SRO_CNT_W'(1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - SRO_CNT_W'(1);
    end
  end

  // Internal reset released only on the clock, never straight from a pin
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_rst <= 1'b1;
      regs_init <= 1'b0;
      fetch_go <= 1'b0;
    end else begin
      core_rst <= (st_nxt != SRO_ST_RUN);
      regs_init <= (st_nxt == SRO_ST_INIT);
      fetch_go <= (st_nxt == SRO_ST_RUN) && (st_r != SRO_ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  assign flag_reg_sel = (addr == SRO_FLAG_REG_ADDR);

  // Hardware cause update wins over a same-cycle software write
  always_ff @(posedge ref_clk) begin
    if (srst || lvd_reset) begin
      cause_r <= SRO_CAUSE_POR;
    end else if (wdt_hit) begin
      cause_r <= SRO_CAUSE_WDT;
    end else if (pin_fall && st_r != SRO_ST_POWER) begin
      cause_r <= SRO_CAUSE_EXT;
    end else if (wr_en && flag_reg_sel) begin
      cause_r <= wr_data[SRO_CAUSE_UP_BIT:SRO_CAUSE_LO_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || lvd_reset) begin
      lv_mid_r <= 1'b0;
      lv_high_r <= 1'b0;
    end else begin
      lv_mid_r <= lvd_mid_in && (opt_lvd == SRO_LVD_M || opt_lvd == SRO_LVD_H);
      lv_high_r <= lvd_high_in && (opt_lvd == SRO_LVD_H);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || st_nxt == SRO_ST_INIT) begin
      alu_r <= SRO_ALU_RST;
    end else if (wr_en && flag_reg_sel) begin
      alu_r <= wr_data[SRO_ALU_MSB:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data <= SRO_RD_IDLE;
    end else if (rd_en && flag_reg_sel) begin
      rd_data <= {cause_r, lv_high_r, lv_mid_r, 1'b0, alu_r};
    end else begin
      rd_data <= SRO_RD_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Clocks and oscillator pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || slow_cnt_r == 10'(SRO_SLOW_DIV_CYC - 1)) begin
      slow_cnt_r <= 10'h000;
    end else begin
      slow_cnt_r <= slow_cnt_r + 10'h001;
    end
    slow_tick_r <= !srst && (slow_cnt_r == 10'(SRO_SLOW_DIV_CYC - 1));
  end

  sro_cpu_div u_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .slow_mode(slow_mode),
    .fcpu_sel(opt_fcpu),
    .slow_tick(slow_tick_r),
    .cyc_tick(cyc_tick)
  );

  always_ff @(posedge ref_clk) begin
    fcpu_tick <= !srst && cyc_tick;
  end

  // Fast pin: instruction clock in RC, GPIO under PLL, idle for crystals
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fast_osc_out_pin_o <= 1'b0;
      fast_osc_out_pin_oe <= 1'b0;
      gpio_in <= 1'b0;
    end else begin
      gpio_in <= (opt_high_clk == SRO_HCLK_PLL) && fast_osc_out_pin_i;
      if (opt_high_clk == SRO_HCLK_RC) begin
        fast_osc_out_pin_oe <= 1'b1;
        fast_osc_out_pin_o <= cyc_tick ? !fast_osc_out_pin_o : fast_osc_out_pin_o;
      end else if (opt_high_clk == SRO_HCLK_PLL) begin
        fast_osc_out_pin_oe <= gpio_oe;
        fast_osc_out_pin_o <= gpio_out;
      end else begin
        fast_osc_out_pin_oe <= 1'b0;
        fast_osc_out_pin_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || opt_low_clk != SRO_LCLK_RC) begin
      slow_osc_out_pin_o <= 1'b0;
      slow_osc_out_pin_oe <= 1'b0;
    end else begin
      slow_osc_out_pin_oe <= 1'b1;
      slow_osc_out_pin_o <= slow_tick_r ? !slow_osc_out_pin_o : slow_osc_out_pin_o;
    end
  end

  // ----------------------------------------------------------------
  // Mode and protection gates
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdt_run <= 1'b0;
      sleep_allowed <= 1'b0;
      green_allowed <= 1'b0;
      rom_dump_grant <= 1'b0;
    end else begin
      wdt_run <= (opt_wdt == SRO_WDT_ON) ||
                 (opt_wdt == SRO_WDT_EN && !power_down_mode && !green_mode);
      sleep_allowed <= !((opt_high_clk == SRO_HCLK_PLL) && (opt_low_clk == SRO_LCLK_XTAL) &&
                         (opt_wdt != SRO_WDT_OFF));
      green_allowed <= 1'b1;
      rom_dump_grant <= rom_dump_req && !opt_security;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wdt_event;
    !lvd_reset && wdt_overflow && opt_wdt != SRO_WDT_OFF && st_r == SRO_ST_RUN;
  endsequence

  sequence s_init_then_warm;
    st_r == SRO_ST_INIT && regs_init && core_rst ##1 st_r == SRO_ST_WARM;
  endsequence

  a_wdt_cause_init: assert property (@(posedge ref_clk) disable iff (srst)
    s_wdt_event |=> s_init_then_warm and (cause_r == SRO_CAUSE_WDT))
    else $error("watchdog overflow did not restart at init with cause 00");

  a_lvd_cause_clear: assert property (@(posedge ref_clk) disable iff (srst)
    lvd_reset |=> st_r == SRO_ST_POWER && cause_r == SRO_CAUSE_POR && !lv_mid_r && !lv_high_r)
    else $error("low-voltage reset left cause or flags wrong");

  a_pin_hold_low: assert property (@(posedge ref_clk) disable iff (srst)
    st_r == SRO_ST_PIN && pin_rst_en && !pin_s2_r && !lvd_reset |=> st_r == SRO_ST_PIN && core_rst)
    else $error("reset released while pin still low");

  a_pin_fall_reset: assert property (@(posedge ref_clk) disable iff (srst)
    st_r == SRO_ST_RUN && pin_fall && !lvd_reset && !wdt_overflow
    |=> st_r == SRO_ST_PIN && cause_r == SRO_CAUSE_EXT && core_rst)
    else $error("pin falling edge did not reset");

  a_input_pin_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    st_r == SRO_ST_RUN && !pin_rst_en && !lvd_reset && !wdt_overflow |=> st_r == SRO_ST_RUN)
    else $error("input-only pin option left the run state");

  a_rc_warm_short: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(st_r == SRO_ST_WARM) && opt_high_clk == SRO_HCLK_RC && $stable(opt_high_clk)
    |-> ##[1:60] st_r != SRO_ST_WARM)
    else $error("RC warm-up overran its count");

  a_run_release: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(core_rst) |-> st_r == SRO_ST_RUN && fetch_go && $past(st_r) == SRO_ST_WARM)
    else $error("release without warm-up or fetch start");

  a_slow_pin_clk: assert property (@(posedge ref_clk) disable iff (srst)
    opt_low_clk == SRO_LCLK_RC && $past(opt_low_clk) == SRO_LCLK_RC && slow_tick_r
    |=> slow_osc_out_pin_oe && slow_osc_out_pin_o != $past(slow_osc_out_pin_o))
    else $error("slow RC clock not driven on its pin");

  a_sleep_block: assert property (@(posedge ref_clk) disable iff (srst)
    opt_high_clk == SRO_HCLK_PLL && opt_low_clk == SRO_LCLK_XTAL && opt_wdt != SRO_WDT_OFF
    |=> !sleep_allowed && green_allowed)
    else $error("sleep allowed under PLL, slow crystal and watchdog");

  a_wdt_stop_lowpow: assert property (@(posedge ref_clk) disable iff (srst)
    opt_wdt == SRO_WDT_EN && (power_down_mode || green_mode) |=> !wdt_run)
    else $error("enabled watchdog kept running in low-power mode");

  a_rom_lock: assert property (@(posedge ref_clk) disable iff (srst)
    opt_security && rom_dump_req |=> !rom_dump_grant)
    else $error("secured program memory was read out");

endmodule : sro_reset_ctrl
`default_nettype wire

/* verif/sro_pin_drv.sv */
`timescale 1ns/100ps
`default_nettype none
module sro_pin_drv (
  input wire logic ref_clk,
  input wire logic hold_low,
  input wire logic [7:0] release_lag,
  output logic rst_pin
);
  logic [7:0] lag_r = 8'h00;
  // ----------------------------------------------------------------
  // External reset circuit
  // ----------------------------------------------------------------
  // A slow circuit keeps the pin low for a while after it is let go
  always @(posedge ref_clk) begin
    if (hold_low) begin
      lag_r <= release_lag;
    end else if (lag_r != 8'h00) begin
      lag_r <= lag_r - 8'h01;
    end
  end
  // Released pin is pulled high by the circuit, never left floating
  assign rst_pin = !(hold_low || (lag_r != 8'h00));
endmodule : sro_pin_drv
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sro_pkg::*;
  localparam int XW = 20;
  logic ref_clk, srst, power_good, wdt_overflow, lvd_reset, lvd_mid_in, lvd_high_in, rst_pin_in;
  logic [1:0] opt_high_clk, opt_wdt, opt_lvd;
  logic [2:0] opt_fcpu;
  logic opt_low_clk, opt_reset_pin, opt_security, slow_mode, power_down_mode, green_mode;
  logic gpio_out, gpio_oe, fast_osc_out_pin_i, rom_dump_req, wr_en, rd_en, hold_low, pin_ext;
  logic [7:0] addr, wr_data, rd_data, release_lag, v;
  logic core_rst, regs_init, fetch_go, fcpu_tick, wdt_run, sleep_allowed, green_allowed;
  logic rom_dump_grant, fast_osc_out_pin_o, fast_osc_out_pin_oe, slow_osc_out_pin_o;
  logic slow_osc_out_pin_oe, gpio_in, gpi_pin_in;
  int mismatches = 0;
  int comparisons = 0;
  int n;

  // Pin level from both drivers: the core when enabled, else the board
  assign fast_osc_out_pin_i = fast_osc_out_pin_oe ? fast_osc_out_pin_o : pin_ext;

  sro_pin_drv pin_u (.ref_clk(ref_clk), .hold_low(hold_low), .release_lag(release_lag), .rst_pin(rst_pin_in));

  sro_reset_ctrl #(.XTAL_WARM_CYC(XW)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .power_good(power_good), .wdt_overflow(wdt_overflow),
    .lvd_reset(lvd_reset), .lvd_mid_in(lvd_mid_in), .lvd_high_in(lvd_high_in), .rst_pin_in(rst_pin_in),
    .opt_high_clk(opt_high_clk), .opt_low_clk(opt_low_clk), .opt_fcpu(opt_fcpu), .opt_wdt(opt_wdt),
    .opt_reset_pin(opt_reset_pin), .opt_security(opt_security), .opt_lvd(opt_lvd), .slow_mode(slow_mode),
    .power_down_mode(power_down_mode), .green_mode(green_mode), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .fast_osc_out_pin_i(fast_osc_out_pin_i), .rom_dump_req(rom_dump_req), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .core_rst(core_rst), .regs_init(regs_init),
    .fetch_go(fetch_go), .fcpu_tick(fcpu_tick), .wdt_run(wdt_run), .sleep_allowed(sleep_allowed),
    .green_allowed(green_allowed), .rom_dump_grant(rom_dump_grant), .fast_osc_out_pin_o(fast_osc_out_pin_o),
    .fast_osc_out_pin_oe(fast_osc_out_pin_oe), .slow_osc_out_pin_o(slow_osc_out_pin_o),
    .slow_osc_out_pin_oe(slow_osc_out_pin_oe), .gpio_in(gpio_in), .gpi_pin_in(gpi_pin_in)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic settle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : settle

  // Bounded wait for fetch_go (0), regs_init (1) or fcpu_tick (2)
  task automatic wait_hi(input int sel, output int cnt);
    logic s;
    cnt = 0;
    s = 1'b0;
    while (s !== 1'b1 && cnt < 20000) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      s = (sel == 0) ? fetch_go : ((sel == 1) ? regs_init : fcpu_tick);
    end
    // A wait that runs out is a failure in itself
    if (s !== 1'b1) begin
      mismatches++;
    end
  endtask : wait_hi

  // A watchdog overflow pulse, then the restart with the given warm-up
  task automatic wdt_restart(input logic [1:0] hclk, input int warm);
    @(posedge ref_clk);
    opt_high_clk <= hclk;
    wdt_overflow <= 1'b1;
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    #1;
    chk(core_rst, 1'b1);
    // The init pulse stands in this very cycle only
    chk(regs_init, 1'b1);
    wait_hi(0, n);
    chk(n, warm + 1);
    chk(core_rst, 1'b0);
  endtask : wdt_restart

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {srst, power_good} = 2'b11;
    {wdt_overflow, lvd_reset, lvd_mid_in, lvd_high_in, wr_en, rd_en, hold_low} = 7'h00;
    {slow_mode, power_down_mode, green_mode, gpio_out, gpio_oe, rom_dump_req, pin_ext} = 7'h00;
    opt_high_clk = SRO_HCLK_RC;
    opt_low_clk = SRO_LCLK_XTAL;
    opt_fcpu = 3'h0;
    opt_wdt = SRO_WDT_EN;
    opt_reset_pin = SRO_PIN_RESET;
    opt_security = 1'b0;
    opt_lvd = SRO_LVD_L;
    {addr, wr_data, release_lag} = 24'h000000;
    settle(19);
    chk(core_rst, 1'b1);
    chk(fetch_go, 1'b0);
    @(posedge ref_clk);
    srst <= 1'b0;
    wait_hi(1, n);
    chk(n >= SRO_POWER_WAIT_CYC && n < SRO_POWER_WAIT_CYC + 10, 1'b1);
    wait_hi(0, n);
    chk(n, SRO_RC_WARM_CYC + 1);
    rd(SRO_FLAG_REG_ADDR, v);
    chk(v, 8'h80);
    chk(rd_data, 8'h80);
    settle(1);
    chk(rd_data, SRO_RD_IDLE);
    rd(8'h85, v);
    chk(v, SRO_RD_IDLE);
    wr(SRO_FLAG_REG_ADDR, 8'hFF);
    rd(SRO_FLAG_REG_ADDR, v);
    chk(v, 8'hC7);
    wdt_restart(SRO_HCLK_RC, SRO_RC_WARM_CYC);
    rd(SRO_FLAG_REG_ADDR, v);
    chk(v, 8'h00);
    wdt_restart(SRO_HCLK_X4, XW);
    @(posedge ref_clk);
    opt_wdt <= SRO_WDT_OFF;
    wdt_overflow <= 1'b1;
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    settle(2);
    chk(core_rst, 1'b0);
    // Pin reset with a slow release by the external circuit
    @(posedge ref_clk);
    opt_high_clk <= SRO_HCLK_RC;
    release_lag <= 8'h10;
    hold_low <= 1'b1;
    settle(6);
    chk(core_rst, 1'b1);
    settle(20);
    chk(core_rst, 1'b1);
    @(posedge ref_clk);
    hold_low <= 1'b0;
    wait_hi(0, n);
    chk(n > 16 + SRO_RC_WARM_CYC, 1'b1);
    rd(SRO_FLAG_REG_ADDR, v);
    chk(v, 8'hC0);
    @(posedge ref_clk);
    opt_reset_pin <= SRO_PIN_INPUT;
    hold_low <= 1'b1;
    settle(8);
    chk(core_rst, 1'b0);
    chk(gpi_pin_in, 1'b0);
    @(posedge ref_clk);
    hold_low <= 1'b0;
    settle(24);
    chk(gpi_pin_in, 1'b1);
    for (int s = 0; s < 5; s++) begin
      @(posedge ref_clk);
      opt_fcpu <= 3'(s);
      wait_hi(2, n);
      wait_hi(2, n);
      wait_hi(2, n);
      chk(n, 1 << s);
      v[0] = fast_osc_out_pin_o;
      wait_hi(2, n);
      chk(fast_osc_out_pin_o, !v[0]);
      chk(fast_osc_out_pin_oe, 1'b1);
    end
    @(posedge ref_clk);
    slow_mode <= 1'b1;
    wait_hi(2, n);
    wait_hi(2, n);
    wait_hi(2, n);
    chk(n, SRO_SLOW_FCPU_DIV * SRO_SLOW_DIV_CYC);
    chk(slow_osc_out_pin_oe, 1'b0);
    @(posedge ref_clk);
    slow_mode <= 1'b0;
    opt_low_clk <= SRO_LCLK_RC;
    settle(3);
    chk(slow_osc_out_pin_oe, 1'b1);
    // Exactly one slow tick falls in any window of one slow period
    v[0] = slow_osc_out_pin_o;
    settle(SRO_SLOW_DIV_CYC);
    chk(slow_osc_out_pin_o, !v[0]);
    // Fast pin as general I/O, driven by the core, then by the board
    @(posedge ref_clk);
    opt_high_clk <= SRO_HCLK_PLL;
    {gpio_oe, gpio_out} <= 2'b11;
    settle(3);
    chk({fast_osc_out_pin_oe, fast_osc_out_pin_o, gpio_in}, 3'h7);
    @(posedge ref_clk);
    {gpio_oe, pin_ext} <= 2'b00;
    settle(3);
    chk({fast_osc_out_pin_oe, gpio_in}, 2'h0);
    @(posedge ref_clk);
    opt_low_clk <= SRO_LCLK_XTAL;
    opt_wdt <= SRO_WDT_EN;
    settle(3);
    chk({sleep_allowed, green_allowed}, 2'h1);
    @(posedge ref_clk);
    opt_wdt <= SRO_WDT_OFF;
    settle(3);
    chk(sleep_allowed, 1'b1);
    @(posedge ref_clk);
    opt_wdt <= SRO_WDT_ON;
    power_down_mode <= 1'b1;
    settle(3);
    chk(wdt_run, 1'b1);
    @(posedge ref_clk);
    opt_wdt <= SRO_WDT_EN;
    settle(3);
    chk(wdt_run, 1'b0);
    @(posedge ref_clk);
    {rom_dump_req, opt_security, power_down_mode} <= 3'b110;
    settle(3);
    chk(rom_dump_grant, 1'b0);
    @(posedge ref_clk);
    opt_security <= 1'b0;
    settle(3);
    chk(rom_dump_grant, 1'b1);
    // Low-voltage flags, then a brown-out reset clears them
    @(posedge ref_clk);
    {opt_lvd, lvd_mid_in, lvd_high_in} <= {SRO_LVD_H, 2'b11};
    rd(SRO_FLAG_REG_ADDR, v);
    chk(v, 8'hF0);
    @(posedge ref_clk);
    lvd_reset <= 1'b1;
    {lvd_mid_in, lvd_high_in} <= 2'b00;
    @(posedge ref_clk);
    lvd_reset <= 1'b0;
    settle(1);
    chk(core_rst, 1'b1);
    wait_hi(0, n);
    rd(SRO_FLAG_REG_ADDR, v);
    chk(v, 8'h80);
    close_out();
  end
endmodule : tb
`default_nettype wire
